//--- shared/svto_pkg.sv
package svto_pkg;
   // object indices used as register addresses
   localparam logic [15:0] IDX_MEASURED_SPEED = 16'h606C;
   localparam logic [15:0] IDX_SPEED_BAND = 16'h606D;
   localparam logic [15:0] IDX_SPEED_DWELL = 16'h606E;
   localparam logic [15:0] IDX_ZERO_BAND = 16'h606F;
   localparam logic [15:0] IDX_ZERO_DWELL = 16'h6070;
   localparam logic [15:0] IDX_TORQUE_GOAL = 16'h6071;
   localparam logic [15:0] IDX_MEASURED_TORQUE = 16'h6077;
   localparam logic [15:0] IDX_POSITION_GOAL = 16'h607A;
   localparam logic [15:0] IDX_HOMING_SHIFT = 16'h607C;
   // reset values
   localparam logic [15:0] RST_SPEED_BAND = 16'h000A;
   localparam logic [15:0] RST_SPEED_DWELL = 16'h0000;
   localparam logic [15:0] RST_ZERO_BAND = 16'h000A;
   localparam logic [15:0] RST_ZERO_DWELL = 16'h0000;
   localparam logic [15:0] RST_TORQUE_GOAL = 16'h0000;
   localparam logic [31:0] RST_POSITION_GOAL = 32'h0000_0000;
   localparam logic [31:0] RST_HOMING_SHIFT = 32'h0000_0000;
   // torque goal limits in 0.1 percent
   localparam logic signed [15:0] TORQUE_MIN = 16'hEC78;
   localparam logic signed [15:0] TORQUE_MAX = 16'h1388;
   // status and control bit positions
   localparam int STAT_REACHED_BIT = 10;
   localparam int CTRL_RELATIVE_BIT = 6;
   // timing: one millisecond at the 25 MHz clock
   localparam int CLK_HZ = 25_000_000;
   localparam int MS_PER_S = 1000;
   localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
   // operation modes
   typedef enum logic [2:0] {
      SVTO_MODE_NONE = 3'b000,
      SVTO_MODE_POINT = 3'b001,
      SVTO_MODE_SPEED = 3'b011,
      SVTO_MODE_TORQUE = 3'b100,
      SVTO_MODE_SYNC_TORQUE = 3'b101
   } svto_mode_t;
endpackage

//--- design/svto_dwell.sv
`timescale 1ns/1ps
// window qualifier: flags done after the condition has held for dwell ms
module svto_dwell #(
   parameter int MS_CYC = 25000
) (
   input wire logic clk_in, // clock
   input wire logic sys_rst_in, // sync reset
   input wire logic cond_in, // window condition
   input wire logic [15:0] dwell_ms_in, // dwell time in ms
   output logic done_out // held long enough
);
   localparam int TICK_W = $clog2(MS_CYC + 1);
   logic [15:0] ms_q;
   logic [TICK_W-1:0] tick_q;

   always_ff @(posedge clk_in) begin
      if (sys_rst_in || !cond_in) begin // see RL17
         tick_q <= '0;
         ms_q <= '0;
      end else if (ms_q < dwell_ms_in) begin // stops at the dwell, so a lowered dwell cannot make it wrap
         if (tick_q == TICK_W'(MS_CYC - 1)) begin
            tick_q <= '0;
            ms_q <= ms_q + 16'h0001;
         end else begin
            tick_q <= tick_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         done_out <= 1'b0;
      end else begin
         done_out <= cond_in && (ms_q >= dwell_ms_in);
      end
   end
endmodule

//--- design/svto_objects.sv
`timescale 1ns/1ps
//Function
//RL1 - in speed profile mode status bit 10 sets after the speed error stays in the band for the dwell time.
//RL2 - the reached bit is only shown while enabled and in speed profile mode.
//RL3 - speed band is a 16-bit read-write object reset to 10.
//RL4 - speed dwell is a 16-bit read-write ms count reset to 0.
//RL5 - zero speed is declared when the speed magnitude stays in the zero band for its dwell.
//RL6 - otherwise zero speed is reported false.
//RL7 - zero speed is evaluated only in speed profile mode, regardless of enable.
//RL8 - zero band and zero dwell are 16-bit read-write objects reset to 10 and 0.
//RL9 - torque goal is a signed 16-bit read-write object clamped to its limits, reset 0.
//RL10 - measured torque is published read-only as signed 16 bits.
//RL11 - measured speed is published read-only as signed 32 bits in all modes.
//RL12 - control bit 6 clear makes the position goal absolute, set makes it relative to segment start.
//RL13 - at segment end the position equals the goal, or the travel equals the goal.
//RL14 - position goal is a signed 32-bit read-write object reset to 0 used in point mode.
//RL15 - the commanded speed in the band check is the target velocity.
//RL16 - when homing ends the actual position is loaded with the homing shift.
//RL17 - each dwell timer restarts whenever its condition drops.
module svto_objects #(
   parameter int MS_CYC = svto_pkg::MS_CYCLES
) (
   input wire logic clk_in, // clock
   input wire logic sys_rst_in, // sync reset
   input wire logic wr_in, // object write strobe
   input wire logic rd_in, // object read strobe
   input wire logic [15:0] index_in, // object index
   input wire logic [31:0] wdata_in, // write data
   output logic [31:0] rdata_out, // read data
   output logic rvalid_out, // read answer pulse
   input wire logic [2:0] mode_in, // operation mode
   input wire logic enabled_in, // drive enabled
   input wire logic [15:0] ctrl_word_in, // control word
   input wire logic signed [31:0] speed_cmd_in, // target velocity
   input wire logic signed [31:0] speed_meas_in, // measured speed
   input wire logic signed [15:0] torque_meas_in, // internal torque
   input wire logic segment_start_in, // new segment pulse
   input wire logic homing_done_in, // homing finished pulse
   input wire logic step_valid_in, // position step pulse
   input wire logic signed [31:0] step_in, // signed step applied
   output logic [15:0] status_out, // status word bits
   output logic zero_speed_out, // velocity is zero
   output logic signed [15:0] torque_goal_out, // torque reference
   output logic signed [31:0] position_out, // actual position
   output logic signed [31:0] segment_goal_out, // absolute segment end
   output logic segment_done_out // segment reached
);
   logic [15:0] speed_band_q;
   logic [15:0] speed_dwell_q;
   logic [15:0] zero_band_q;
   logic [15:0] zero_dwell_q;
   logic signed [15:0] torque_goal_q;
   logic signed [31:0] position_goal_q;
   logic signed [31:0] homing_shift_q;
   logic signed [31:0] speed_q;
   logic signed [15:0] torque_q;
   logic signed [31:0] pos_q;
   logic signed [31:0] seg_start_q;
   logic signed [31:0] seg_goal_q;
   logic seg_active_q;
   logic seg_done_q;
   logic reached_q;
   logic zero_q;
   logic [31:0] rdata_q;
   logic rvalid_q;
   logic speed_mode;
   logic in_speed_band;
   logic in_zero_band;
   logic speed_ok;
   logic zero_ok;
   logic signed [31:0] next_pos;
   logic signed [31:0] seg_goal_d;

   function automatic logic [32:0] abs33(input logic signed [32:0] v);
      abs33 = v[32] ? 33'(-v) : v;
   endfunction

   function automatic logic signed [15:0] clamp_torque(input logic signed [31:0] v);
      if (v < 32'(svto_pkg::TORQUE_MIN)) begin
         clamp_torque = svto_pkg::TORQUE_MIN;
      end else if (v > 32'(svto_pkg::TORQUE_MAX)) begin
         clamp_torque = svto_pkg::TORQUE_MAX;
      end else begin
         clamp_torque = v[15:0];
      end
   endfunction

   assign speed_mode = (mode_in == svto_pkg::SVTO_MODE_SPEED);
   // see RL15
   assign in_speed_band = abs33(33'(speed_cmd_in) - 33'(speed_meas_in)) <= {17'h0_0000, speed_band_q};
   assign in_zero_band = abs33(33'(speed_meas_in)) <= {17'h0_0000, zero_band_q};
   assign next_pos = pos_q + step_in;

   svto_dwell #(.MS_CYC(MS_CYC)) u_speed_dwell (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .cond_in(speed_mode && enabled_in && in_speed_band),
      .dwell_ms_in(speed_dwell_q),
      .done_out(speed_ok)
   );

   svto_dwell #(.MS_CYC(MS_CYC)) u_zero_dwell (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .cond_in(speed_mode && in_zero_band),
      .dwell_ms_in(zero_dwell_q),
      .done_out(zero_ok)
   );

   // writable objects
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         speed_band_q <= svto_pkg::RST_SPEED_BAND; // see RL3
         speed_dwell_q <= svto_pkg::RST_SPEED_DWELL; // see RL4
         zero_band_q <= svto_pkg::RST_ZERO_BAND; // see RL8
         zero_dwell_q <= svto_pkg::RST_ZERO_DWELL; // see RL8
         torque_goal_q <= svto_pkg::RST_TORQUE_GOAL;
         position_goal_q <= svto_pkg::RST_POSITION_GOAL; // see RL14
         homing_shift_q <= svto_pkg::RST_HOMING_SHIFT;
      end else if (wr_in) begin
         if (index_in == svto_pkg::IDX_SPEED_BAND) begin
            speed_band_q <= wdata_in[15:0];
         end else if (index_in == svto_pkg::IDX_SPEED_DWELL) begin
            speed_dwell_q <= wdata_in[15:0];
         end else if (index_in == svto_pkg::IDX_ZERO_BAND) begin
            zero_band_q <= wdata_in[15:0];
         end else if (index_in == svto_pkg::IDX_ZERO_DWELL) begin
            zero_dwell_q <= wdata_in[15:0];
         end else if (index_in == svto_pkg::IDX_TORQUE_GOAL) begin
            torque_goal_q <= clamp_torque({{16{wdata_in[15]}}, wdata_in[15:0]}); // see RL9
         end else if (index_in == svto_pkg::IDX_POSITION_GOAL) begin
            position_goal_q <= wdata_in;
         end else if (index_in == svto_pkg::IDX_HOMING_SHIFT) begin
            homing_shift_q <= wdata_in;
         end
      end
   end

   // sampled actual values
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         speed_q <= '0;
         torque_q <= '0;
      end else begin
         speed_q <= speed_meas_in; // see RL11
         torque_q <= torque_meas_in; // see RL10
      end
   end

   // read port, answer on rvalid_out two cycles after the strobe
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         rdata_q <= '0;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= rd_in;
         if (rd_in) begin
            if (index_in == svto_pkg::IDX_MEASURED_SPEED) begin
               rdata_q <= speed_q;
            end else if (index_in == svto_pkg::IDX_SPEED_BAND) begin
               rdata_q <= {16'h0000, speed_band_q};
            end else if (index_in == svto_pkg::IDX_SPEED_DWELL) begin
               rdata_q <= {16'h0000, speed_dwell_q};
            end else if (index_in == svto_pkg::IDX_ZERO_BAND) begin
               rdata_q <= {16'h0000, zero_band_q};
            end else if (index_in == svto_pkg::IDX_ZERO_DWELL) begin
               rdata_q <= {16'h0000, zero_dwell_q};
            end else if (index_in == svto_pkg::IDX_TORQUE_GOAL) begin
               rdata_q <= {{16{torque_goal_q[15]}}, torque_goal_q};
            end else if (index_in == svto_pkg::IDX_MEASURED_TORQUE) begin
               rdata_q <= {{16{torque_q[15]}}, torque_q};
            end else if (index_in == svto_pkg::IDX_POSITION_GOAL) begin
               rdata_q <= position_goal_q;
            end else if (index_in == svto_pkg::IDX_HOMING_SHIFT) begin
               rdata_q <= homing_shift_q;
            end else begin
               rdata_q <= '0;
            end
         end
      end
   end

   // speed indications
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         reached_q <= 1'b0;
         zero_q <= 1'b0;
      end else begin
         reached_q <= speed_ok && speed_mode && enabled_in; // see RL1 see RL2
         zero_q <= zero_ok && speed_mode && in_zero_band; // see RL5 see RL6 see RL7
      end
   end

   // segment goal: absolute or relative to the segment start
   always_comb begin
      if (ctrl_word_in[svto_pkg::CTRL_RELATIVE_BIT]) begin
         seg_goal_d = pos_q + position_goal_q; // see RL12
      end else begin
         seg_goal_d = position_goal_q; // see RL12
      end
   end

   // position tracking and segment completion
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         pos_q <= '0;
         seg_start_q <= '0;
         seg_goal_q <= '0;
         seg_active_q <= 1'b0;
         seg_done_q <= 1'b0;
      end else if (homing_done_in) begin
         pos_q <= homing_shift_q; // see RL16
         seg_active_q <= 1'b0;
         seg_done_q <= 1'b0;
      end else if (segment_start_in && mode_in == svto_pkg::SVTO_MODE_POINT) begin
         seg_start_q <= pos_q;
         seg_goal_q <= seg_goal_d;
         seg_active_q <= 1'b1;
         seg_done_q <= 1'b0;
      end else if (seg_active_q) begin
         if (step_valid_in) begin
            // the last step is trimmed so the segment lands on the goal exactly
            if ((step_in >= 0 && next_pos >= seg_goal_q) || (step_in < 0 && next_pos <= seg_goal_q)) begin
               pos_q <= seg_goal_q; // see RL13
               seg_active_q <= 1'b0;
               seg_done_q <= 1'b1;
            end else begin
               pos_q <= next_pos;
            end
         end else if (pos_q == seg_goal_q) begin
            seg_active_q <= 1'b0;
            seg_done_q <= 1'b1;
         end
      end else if (step_valid_in) begin
         pos_q <= next_pos;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         status_out <= '0;
         zero_speed_out <= 1'b0;
         torque_goal_out <= '0;
         position_out <= '0;
         segment_goal_out <= '0;
         segment_done_out <= 1'b0;
         rdata_out <= '0;
         rvalid_out <= 1'b0;
      end else begin
         status_out <= 16'(reached_q) << svto_pkg::STAT_REACHED_BIT;
         zero_speed_out <= zero_q;
         torque_goal_out <= torque_goal_q;
         position_out <= pos_q;
         segment_goal_out <= seg_goal_q;
         segment_done_out <= seg_done_q;
         rdata_out <= rdata_q;
         rvalid_out <= rvalid_q;
      end
   end

   property p_reached_needs_mode;
      @(posedge clk_in) disable iff (sys_rst_in)
      status_out[svto_pkg::STAT_REACHED_BIT] |-> $past(speed_mode, 3) && $past(enabled_in, 3);
   endproperty
   a_reached_needs_mode: assert property (p_reached_needs_mode) else $error("reached outside enabled speed mode"); // see RL2

   property p_reached_band;
      @(posedge clk_in) disable iff (sys_rst_in)
      status_out[svto_pkg::STAT_REACHED_BIT] |-> $past(in_speed_band, 3);
   endproperty
   a_reached_band: assert property (p_reached_band) else $error("reached while out of band"); // see RL1

   property p_zero_drop;
      @(posedge clk_in) disable iff (sys_rst_in)
      !in_zero_band |=> ##1 !zero_speed_out;
   endproperty
   a_zero_drop: assert property (p_zero_drop) else $error("zero speed held out of band"); // see RL6

   property p_zero_mode;
      @(posedge clk_in) disable iff (sys_rst_in)
      zero_speed_out |-> $past(speed_mode, 2);
   endproperty
   a_zero_mode: assert property (p_zero_mode) else $error("zero speed outside speed mode"); // see RL7

   property p_zero_fast;
      @(posedge clk_in) disable iff (sys_rst_in)
      (speed_mode && in_zero_band && zero_dwell_q == 16'h0000)[*4] |-> zero_speed_out;
   endproperty
   a_zero_fast: assert property (p_zero_fast) else $error("zero speed missing with zero dwell"); // see RL5

   property p_torque_limit;
      @(posedge clk_in) disable iff (sys_rst_in)
      torque_goal_out >= svto_pkg::TORQUE_MIN && torque_goal_out <= svto_pkg::TORQUE_MAX;
   endproperty
   a_torque_limit: assert property (p_torque_limit) else $error("torque goal out of limits"); // see RL9

   property p_homing_load;
      @(posedge clk_in) disable iff (sys_rst_in)
      homing_done_in |=> ##1 position_out == $past(homing_shift_q, 2);
   endproperty
   a_homing_load: assert property (p_homing_load) else $error("homing shift not loaded"); // see RL16

   property p_seg_land;
      @(posedge clk_in) disable iff (sys_rst_in)
      $rose(seg_done_q) |-> pos_q == seg_goal_q;
   endproperty
   a_seg_land: assert property (p_seg_land) else $error("segment ended off goal"); // see RL13

   property p_rel_goal;
      @(posedge clk_in) disable iff (sys_rst_in)
      (segment_start_in && mode_in == svto_pkg::SVTO_MODE_POINT && !homing_done_in
         && ctrl_word_in[svto_pkg::CTRL_RELATIVE_BIT]) |=> seg_goal_q == seg_start_q + $past(position_goal_q);
   endproperty
   a_rel_goal: assert property (p_rel_goal) else $error("relative goal wrong"); // see RL12

   property p_read_speed;
      @(posedge clk_in) disable iff (sys_rst_in)
      rd_in && index_in == svto_pkg::IDX_MEASURED_SPEED |=> ##1 rvalid_out && rdata_out == $past(speed_q, 2);
   endproperty
   a_read_speed: assert property (p_read_speed) else $error("measured speed read wrong"); // see RL11

   c_reached: cover property (@(posedge clk_in) $rose(status_out[svto_pkg::STAT_REACHED_BIT]));
   c_zero: cover property (@(posedge clk_in) $rose(zero_speed_out));
   c_segment: cover property (@(posedge clk_in) $rose(segment_done_out));
   c_homing: cover property (@(posedge clk_in) homing_done_in);
endmodule

//--- verif/svto_master_model.sv
`timescale 1ns/1ps
// fieldbus master side of the object bus: one strobe per access, data taken on the answer pulse
module svto_master_model (
   input wire logic clk_in, // clock
   output logic wr_out, // write strobe
   output logic rd_out, // read strobe
   output logic [15:0] index_out, // object index
   output logic [31:0] wdata_out, // write data
   input wire logic [31:0] rdata_in, // read data
   input wire logic rvalid_in // read answer pulse
);
   initial begin
      wr_out = 1'b0;
      rd_out = 1'b0;
      index_out = 16'h0000;
      wdata_out = 32'h0000_0000;
   end
   task automatic obj_write(input logic [15:0] idx, input logic [31:0] data);
      @(posedge clk_in);
      #1;
      wr_out = 1'b1;
      index_out = idx;
      wdata_out = data;
      @(posedge clk_in);
      #1;
      wr_out = 1'b0;
      // released lines do not keep their last value
      index_out = ~idx;
      wdata_out = ~data;
   endtask
   task automatic obj_read(input logic [15:0] idx, output logic [31:0] data);
      int n;
      data = 32'hxxxx_xxxx;
      @(posedge clk_in);
      #1;
      rd_out = 1'b1;
      index_out = idx;
      @(posedge clk_in);
      #1;
      rd_out = 1'b0;
      index_out = ~idx;
      n = 0;
      while (rvalid_in !== 1'b1 && n < 6) begin
         @(posedge clk_in);
         #1;
         n++;
      end
      if (rvalid_in === 1'b1)
         data = rdata_in;
   endtask
endmodule

//--- verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   typedef struct packed {
      logic wr;
      logic [15:0] idx;
      logic [31:0] wd;
      logic [31:0] exp;
   } svto_row_t;
   logic clk_in, sys_rst_in, wr, rd, rvalid, en, seg_start, hom_done, step_v, seg_done, zero;
   logic [15:0] index, ctrl, status;
   logic [31:0] wdata, rdata, got;
   logic [2:0] mode;
   logic signed [31:0] cmd, meas, step, pos, seg_goal;
   logic signed [15:0] tq_meas, tq_goal;
   int err_total = 0;
   int tests_run = 0;
   int cyc = 0;
   svto_row_t rows [19] = '{
      '{1'b0, 16'h606D, 32'h0, 32'h0000_000A}, '{1'b0, 16'h606E, 32'h0, 32'h0},
      '{1'b0, 16'h606F, 32'h0, 32'h0000_000A}, '{1'b0, 16'h6070, 32'h0, 32'h0},
      '{1'b0, 16'h6071, 32'h0, 32'h0}, '{1'b0, 16'h607A, 32'h0, 32'h0}, '{1'b0, 16'h607C, 32'h0, 32'h0},
      '{1'b1, 16'h606D, 32'h0000_FFFF, 32'h0000_FFFF}, '{1'b1, 16'h606E, 32'h0000_1234, 32'h0000_1234},
      '{1'b1, 16'h606F, 32'h0000_0005, 32'h0000_0005}, '{1'b1, 16'h6070, 32'h0000_0003, 32'h0000_0003},
      '{1'b1, 16'h6071, 32'h0000_2000, 32'h0000_1388}, '{1'b1, 16'h6071, 32'h0000_E000, 32'hFFFF_EC78},
      '{1'b1, 16'h6071, 32'h0000_FFF6, 32'hFFFF_FFF6}, '{1'b1, 16'h607A, 32'h8000_0001, 32'h8000_0001},
      '{1'b1, 16'h607C, 32'h0000_0064, 32'h0000_0064}, '{1'b1, 16'h6077, 32'h0000_1234, 32'hFFFF_FFFB},
      '{1'b1, 16'h606C, 32'h0000_1234, 32'hFFFF_FFF9}, '{1'b1, 16'h6075, 32'h0000_0055, 32'h0}};

   svto_objects #(.MS_CYC(4)) u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .wr_in(wr), .rd_in(rd),
      .index_in(index), .wdata_in(wdata), .rdata_out(rdata), .rvalid_out(rvalid), .mode_in(mode),
      .enabled_in(en), .ctrl_word_in(ctrl), .speed_cmd_in(cmd), .speed_meas_in(meas), .torque_meas_in(tq_meas),
      .segment_start_in(seg_start), .homing_done_in(hom_done), .step_valid_in(step_v), .step_in(step),
      .status_out(status), .zero_speed_out(zero), .torque_goal_out(tq_goal), .position_out(pos),
      .segment_goal_out(seg_goal), .segment_done_out(seg_done));
   svto_master_model u_master (.clk_in(clk_in), .wr_out(wr), .rd_out(rd), .index_out(index),
      .wdata_out(wdata), .rdata_in(rdata), .rvalid_in(rvalid));

   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check_val(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic pulse_seg;
      seg_start = 1'b1;
      tick(1);
      seg_start = 1'b0;
      tick(2);
   endtask
   task automatic pulse_step(input logic signed [31:0] s);
      step = s;
      step_v = 1'b1;
      tick(1);
      step_v = 1'b0;
      step = ~s;
      tick(2);
   endtask

   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         err_total++;
         report_and_stop();
      end
   end

   initial begin
      sys_rst_in = 1'b1;
      mode = svto_pkg::SVTO_MODE_NONE;
      {en, seg_start, hom_done, step_v} = 4'h0;
      ctrl = 16'h0000;
      cmd = 32'h0000_0000;
      meas = -32'sd7;
      tq_meas = -16'sd5;
      step = 32'h0000_0000;
      tick(16);
      check_val("status in reset", 32'(status), 32'h0);
      check_val("position in reset", pos, 32'h0);
      sys_rst_in = 1'b0;
      foreach (rows[i]) begin
         if (rows[i].wr)
            u_master.obj_write(rows[i].idx, rows[i].wd);
         u_master.obj_read(rows[i].idx, got);
         check_val($sformatf("object %h", rows[i].idx), got, rows[i].exp);
      end
      check_val("torque goal", {16'h0000, tq_goal}, 32'h0000_FFF6);
      // speed reached at the exact band edge, then band exceeded by one
      u_master.obj_write(16'h606D, 32'h0000_000A);
      u_master.obj_write(16'h606F, 32'h0000_000A);
      u_master.obj_write(16'h606E, 32'h0);
      u_master.obj_write(16'h6070, 32'h0);
      mode = svto_pkg::SVTO_MODE_SPEED;
      en = 1'b1;
      cmd = -32'sd500;
      meas = -32'sd490;
      tick(4);
      check_val("reached", 32'(status), 32'h0000_0400);
      check_val("not zero", 32'(zero), 32'h0);
      meas = -32'sd489;
      tick(4);
      check_val("reached off", 32'(status), 32'h0);
      meas = -32'sd495;
      en = 1'b0;
      tick(4);
      check_val("reached disabled", 32'(status), 32'h0);
      en = 1'b1;
      mode = svto_pkg::SVTO_MODE_TORQUE;
      tick(4);
      check_val("reached other mode", 32'(status), 32'h0);
      // dwell of 2 ms is 8 cycles here; a break in the band restarts it
      mode = svto_pkg::SVTO_MODE_SPEED;
      meas = 32'sd0;
      u_master.obj_write(16'h606E, 32'h0000_0002);
      meas = -32'sd495;
      tick(5);
      check_val("dwell early", 32'(status), 32'h0);
      tick(9);
      check_val("dwell done", 32'(status), 32'h0000_0400);
      meas = 32'sd0;
      tick(4);
      check_val("dwell drop", 32'(status), 32'h0);
      meas = -32'sd495;
      tick(6);
      meas = 32'sd0;
      tick(1);
      meas = -32'sd495;
      tick(6);
      check_val("dwell restart", 32'(status), 32'h0);
      tick(8);
      check_val("dwell after restart", 32'(status), 32'h0000_0400);
      // zero speed ignores enable and holds only in speed profile mode
      en = 1'b0;
      meas = -32'sd10;
      tick(4);
      check_val("zero", 32'(zero), 32'h1);
      meas = 32'sd11;
      tick(3);
      check_val("zero leave", 32'(zero), 32'h0);
      meas = 32'sd3;
      mode = svto_pkg::SVTO_MODE_POINT;
      tick(3);
      check_val("zero other mode", 32'(zero), 32'h0);
      u_master.obj_write(16'h6070, 32'h0000_0001);
      mode = svto_pkg::SVTO_MODE_SPEED;
      tick(3);
      check_val("zero dwell early", 32'(zero), 32'h0);
      tick(6);
      check_val("zero dwell done", 32'(zero), 32'h1);
      // homing loads 100, then an absolute and a relative segment
      hom_done = 1'b1;
      tick(1);
      hom_done = 1'b0;
      tick(2);
      check_val("homed position", pos, 32'h0000_0064);
      mode = svto_pkg::SVTO_MODE_POINT;
      u_master.obj_write(16'h607A, 32'h0000_0082);
      pulse_seg();
      check_val("absolute goal", seg_goal, 32'h0000_0082);
      pulse_step(32'sd20);
      check_val("step position", pos, 32'h0000_0078);
      check_val("not done", 32'(seg_done), 32'h0);
      pulse_step(32'sd20);
      check_val("absolute end", pos, 32'h0000_0082);
      check_val("absolute done", 32'(seg_done), 32'h1);
      ctrl = 16'h0040;
      u_master.obj_write(16'h607A, 32'hFFFF_FFE2);
      pulse_seg();
      check_val("relative goal", seg_goal, 32'h0000_0064);
      pulse_step(-32'sd20);
      pulse_step(-32'sd20);
      check_val("relative end", pos, 32'h0000_0064);
      check_val("relative done", 32'(seg_done), 32'h1);
      // a reset in mid-run restores the defaults
      u_master.obj_write(16'h606D, 32'h0000_0033);
      sys_rst_in = 1'b1;
      tick(2);
      check_val("position after reset", pos, 32'h0);
      check_val("done after reset", 32'(seg_done), 32'h0);
      sys_rst_in = 1'b0;
      u_master.obj_read(16'h606D, got);
      check_val("band after reset", got, 32'h0000_000A);
      report_and_stop();
   end
endmodule
